/* File: hw/cpc_pkg.sv */
package cpc_pkg;

    // APB word offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_AUX  = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;

    // Control register field positions
    localparam int BIT_RESET    = 15;
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_SPD_LSB  = 13;
    localparam int BIT_AN_EN    = 12;
    localparam int BIT_POWER_DOWN_STRAP    = 11;
    localparam int BIT_ISOLATE  = 10;
    localparam int BIT_RESTART  = 9;
    localparam int BIT_DUPLEX   = 8;
    localparam int BIT_SPD_MSB  = 6;

    // Auxiliary register fields
    localparam int AUX_LB_SPD_LSB = 0;
    localparam int AUX_PDOWN2     = 3;

    // Status register fields
    localparam int STAT_SPD_LSB  = 0;
    localparam int STAT_DUPLEX   = 2;
    localparam int STAT_AN_EN    = 3;
    localparam int STAT_POWER_DOWN_STRAP    = 4;
    localparam int STAT_IN_RESET = 5;
    localparam int STAT_ADV_1000 = 6;

    // Speed codes (MSB from bit 6, LSB from bit 13)
    localparam logic [1:0] SPD_10   = 2'h0;
    localparam logic [1:0] SPD_100  = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;

    // Reset values
    localparam logic [2:0] LB_SPD_RST = 3'h0;

    // Soft reset duration
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SW_RESET_NS     = 100;
    localparam int SW_RESET_CYCLES = (SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SW_RESET_LAST = 8'(SW_RESET_CYCLES - 1);

    typedef struct packed {
        logic [1:0] speed;
        logic       duplex;
        logic       an_en;
    } cpc_cfg_s;

    localparam cpc_cfg_s CFG_RST = '{speed: SPD_1000, duplex: 1'b1, an_en: 1'b1};

    typedef enum logic [2:0] {
        ST_INIT  = 3'h1,
        ST_RUN   = 3'h2,
        ST_SWRST = 3'h4
    } cpc_state_e;

endpackage

/* File: hw/cpc_ctrl.sv */
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

// Function
// (RL1) Writing one to bit 15 resets copper state machines at once.
// (RL2) Bit 15 self-clears when reset finishes; reads zero after hardware reset.
// (RL3) Bit 14 loops transmit data back to receive internally; resets to zero.
// (RL4) Loopback drops line link; loopback speed comes from its own field.
// (RL5) Speed bits 6,13: 00 10M, 01 100M, 10 1000M, 11 reserved.
// (RL6) Speed, duplex, autoneg writes stay pending until reset, restart or wake.
// (RL7) Autoneg enable bit turns negotiation on or off; resets to one.
// (RL8) Autoneg off at forced 1000M still negotiates, advertising only 1000BASE-T.
// (RL9) Stay powered down until both power down bits are zero.
// (RL10) Leaving power down performs soft reset and autoneg restart.
// (RL11) Power down loads strap and mode check at hardware reset; soft reset keeps it.
// (RL12) Isolate bit is read-only zero and does nothing.
// (RL13) Restart bit restarts autoneg and self-clears; any reset also restarts.
// (RL14) Duplex bit: one full, zero half; resets to one; writes staged.
module cpc_ctrl (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // Straps
    input  wire logic          power_down_strap,
    input  wire logic [2:0]    mode_strap,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    // Copper port control
    output logic               copper_sw_reset,
    output logic               an_restart,
    output cpc_pkg::cpc_cfg_s  active_cfg,
    output logic               an_enable_eff,
    output logic               adv_1000_only,
    output logic               loopback_en,
    output logic               line_link_drop,
    output logic [2:0]         loopback_speed,
    output logic               powered_down
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    cpc_pkg::cpc_state_e state;
    cpc_pkg::cpc_state_e next_state;
    logic [7:0]          rst_cnt;
    logic [7:0]          next_rst_cnt;
    cpc_pkg::cpc_cfg_s   staged;
    cpc_pkg::cpc_cfg_s   next_staged;
    cpc_pkg::cpc_cfg_s   next_active_cfg;
    logic                pd_ctrl;
    logic                next_pd_ctrl;
    logic                pd_aux;
    logic                next_pd_aux;
    logic                restart_bit;
    logic                next_restart_bit;
    logic                next_loopback_en;
    logic [2:0]          next_loopback_speed;
    logic                next_copper_sw_reset;
    logic                next_an_restart;
    logic                next_an_enable_eff;
    logic                next_adv_1000_only;
    logic                next_powered_down;
    logic                next_pready;
    logic [31:0]         next_prdata;
    logic                next_pslverr;

    logic                acc;
    logic                wr_ctrl;
    logic                wr_aux;
    logic                pd_exit;
    logic                start_rst;
    logic                restart_req;
    logic                strap_pd;
    logic [15:0]         ctrl_rd;
    logic [31:0]         aux_rd;
    logic [31:0]         stat_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Read views

    always_comb
    begin
        ctrl_rd                         = 16'h0000;
        ctrl_rd[cpc_pkg::BIT_RESET]     = (state == cpc_pkg::ST_SWRST);  // [RL2]
        ctrl_rd[cpc_pkg::BIT_LOOPBACK]  = loopback_en;
        ctrl_rd[cpc_pkg::BIT_SPD_LSB]   = staged.speed[0];               // [RL5]
        ctrl_rd[cpc_pkg::BIT_AN_EN]     = staged.an_en;
        ctrl_rd[cpc_pkg::BIT_POWER_DOWN_STRAP]     = pd_ctrl;
        ctrl_rd[cpc_pkg::BIT_ISOLATE]   = 1'b0;                          // [RL12]
        ctrl_rd[cpc_pkg::BIT_RESTART]   = restart_bit;
        ctrl_rd[cpc_pkg::BIT_DUPLEX]    = staged.duplex;
        ctrl_rd[cpc_pkg::BIT_SPD_MSB]   = staged.speed[1];
        aux_rd                          = 32'h0000_0000;
        aux_rd[cpc_pkg::AUX_LB_SPD_LSB +: 3] = loopback_speed;
        aux_rd[cpc_pkg::AUX_PDOWN2]     = pd_aux;
        stat_rd                         = 32'h0000_0000;
        stat_rd[cpc_pkg::STAT_SPD_LSB +: 2] = active_cfg.speed;
        stat_rd[cpc_pkg::STAT_DUPLEX]   = active_cfg.duplex;
        stat_rd[cpc_pkg::STAT_AN_EN]    = active_cfg.an_en;
        stat_rd[cpc_pkg::STAT_POWER_DOWN_STRAP]    = powered_down;
        stat_rd[cpc_pkg::STAT_IN_RESET] = copper_sw_reset;
        stat_rd[cpc_pkg::STAT_ADV_1000] = adv_1000_only;
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, answer held off until straps are caught

    always_comb
    begin
        acc          = psel && penable && pready;
        next_pready  = psel && penable && !pready && (state != cpc_pkg::ST_INIT);
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (next_pready)
        begin
            // Unmapped offsets answer with an error and touch nothing
            unique case (paddr)
                cpc_pkg::ADDR_CTRL: next_prdata = {16'h0000, ctrl_rd};
                cpc_pkg::ADDR_AUX:  next_prdata = aux_rd;
                cpc_pkg::ADDR_STAT: next_prdata = stat_rd;
                default:            next_pslverr = 1'b1;
            endcase
            // Writes return zero so stale read data never reaches the bus
            if (pwrite)
            begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register behaviour

    always_comb
    begin
        wr_ctrl  = acc && pwrite && (paddr == cpc_pkg::ADDR_CTRL);
        wr_aux   = acc && pwrite && (paddr == cpc_pkg::ADDR_AUX);
        // Strap needs mode 00x or 11x to power down
        strap_pd = power_down_strap && (mode_strap[2] == mode_strap[1]);  // [RL11]

        next_state          = state;
        next_rst_cnt        = rst_cnt;
        next_staged         = staged;
        next_active_cfg     = active_cfg;
        next_pd_ctrl        = pd_ctrl;
        next_pd_aux         = pd_aux;
        next_loopback_en    = loopback_en;
        next_loopback_speed = loopback_speed;
        next_an_restart     = 1'b0;

        if (wr_ctrl)
        begin
            // Reserved speed code is stored as written; nothing here decodes it
            next_staged.speed  = {pwdata[cpc_pkg::BIT_SPD_MSB],
                                  pwdata[cpc_pkg::BIT_SPD_LSB]};            // [RL5] [RL6]
            next_staged.an_en  = pwdata[cpc_pkg::BIT_AN_EN];              // [RL7]
            next_staged.duplex = pwdata[cpc_pkg::BIT_DUPLEX];             // [RL14]
            next_pd_ctrl       = pwdata[cpc_pkg::BIT_POWER_DOWN_STRAP];
        end
        if (wr_aux)
        begin
            next_loopback_speed = pwdata[cpc_pkg::AUX_LB_SPD_LSB +: 3];   // [RL4]
            next_pd_aux         = pwdata[cpc_pkg::AUX_PDOWN2];
        end

        // Wake only when both power down bits are clear
        pd_exit     = (pd_ctrl || pd_aux) && !(next_pd_ctrl || next_pd_aux);  // [RL9]
        start_rst   = (wr_ctrl && pwdata[cpc_pkg::BIT_RESET]) || pd_exit;     // [RL1] [RL10]
        restart_req = (wr_ctrl && pwdata[cpc_pkg::BIT_RESTART]) || pd_exit;   // [RL13] [RL10]

        // Soft reset clears loopback; a loopback write in the same cycle wins
        if (start_rst)
        begin
            next_loopback_en = 1'b0;
        end
        if (wr_ctrl)
        begin
            next_loopback_en = pwdata[cpc_pkg::BIT_LOOPBACK];               // [RL3]
        end

        // Pending settings become live on reset, restart or wake
        if (start_rst || restart_req)
        begin
            next_active_cfg = next_staged;                                // [RL6]
        end

        // Counter loads its last index, so a soft reset stands SW_RESET_CYCLES cycles
        unique case (state)
            cpc_pkg::ST_INIT:
            begin
                // Strap caught after reset release, never under async reset
                next_pd_ctrl    = strap_pd;                               // [RL11]
                next_an_restart = 1'b1;                                   // [RL13]
                next_state      = cpc_pkg::ST_RUN;
            end
            cpc_pkg::ST_RUN:
            begin
                if (start_rst)
                begin
                    next_state   = cpc_pkg::ST_SWRST;                     // [RL1]
                    next_rst_cnt = cpc_pkg::SW_RESET_LAST;
                end
            end
            cpc_pkg::ST_SWRST:
            begin
                if (start_rst)
                begin
                    // A new request restarts the count rather than being lost
                    next_rst_cnt = cpc_pkg::SW_RESET_LAST;
                end
                else if (rst_cnt == 8'h00)
                begin
                    next_state      = cpc_pkg::ST_RUN;                    // [RL2]
                    next_an_restart = 1'b1;                               // [RL13]
                end
                else
                begin
                    next_rst_cnt = rst_cnt - 8'h01;
                end
            end
        endcase
        if (restart_req)
        begin
            next_an_restart = 1'b1;                                       // [RL13]
        end

        // Restart bit reads one for a single cycle, then clears itself
        next_restart_bit     = restart_req;                               // [RL13]
        next_copper_sw_reset = (next_state == cpc_pkg::ST_SWRST);         // [RL1]
        // Either bit alone keeps the port asleep
        next_powered_down    = next_pd_ctrl || next_pd_aux;               // [RL9]
        // Gigabit needs negotiation, so forcing 1000M keeps it running
        next_adv_1000_only   = !next_active_cfg.an_en
                               && (next_active_cfg.speed == cpc_pkg::SPD_1000);  // [RL8]
        next_an_enable_eff   = next_active_cfg.an_en || next_adv_1000_only;      // [RL7] [RL8]
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state           <= cpc_pkg::ST_INIT;
            rst_cnt         <= 8'h00;
            staged          <= cpc_pkg::CFG_RST;
            active_cfg      <= cpc_pkg::CFG_RST;
            pd_ctrl         <= 1'b0;
            pd_aux          <= 1'b0;
            restart_bit     <= 1'b0;
            loopback_en     <= 1'b0;
            line_link_drop  <= 1'b0;
            loopback_speed  <= cpc_pkg::LB_SPD_RST;
            copper_sw_reset <= 1'b0;
            an_restart      <= 1'b0;
            an_enable_eff   <= 1'b1;
            adv_1000_only   <= 1'b0;
            powered_down    <= 1'b0;
        end
        else
        begin
            state           <= next_state;
            rst_cnt         <= next_rst_cnt;
            staged          <= next_staged;
            active_cfg      <= next_active_cfg;
            pd_ctrl         <= next_pd_ctrl;
            pd_aux          <= next_pd_aux;
            restart_bit     <= next_restart_bit;
            loopback_en     <= next_loopback_en;                          // [RL3]
            line_link_drop  <= next_loopback_en;                          // [RL4]
            loopback_speed  <= next_loopback_speed;
            copper_sw_reset <= next_copper_sw_reset;
            an_restart      <= next_an_restart;
            an_enable_eff   <= next_an_enable_eff;
            adv_1000_only   <= next_adv_1000_only;
            powered_down    <= next_powered_down;
        end
    end

endmodule // cpc_ctrl

`default_nettype wire

/* File: testbench/cpc_ctrl_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module cpc_ctrl_monitor (
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset_n,
    // Observed outputs
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              copper_sw_reset,
    input wire logic              an_restart,
    input wire cpc_pkg::cpc_cfg_s active_cfg,
    input wire logic              an_enable_eff,
    input wire logic              adv_1000_only,
    input wire logic              loopback_en,
    input wire logic              line_link_drop
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////////
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    link_drop_a: assert property (line_link_drop == loopback_en)
        else $error("link drop differs from loopback");
    // Outputs change in the same cycle as the config, yet are only judged once it settles
    adv_only_a: assert property ($stable(active_cfg) |-> adv_1000_only ==
        (!active_cfg.an_en && active_cfg.speed == cpc_pkg::SPD_1000))
        else $error("advertise-only flag wrong");
    an_running_a: assert property ($stable(active_cfg) |-> an_enable_eff ==
        (active_cfg.an_en || active_cfg.speed == cpc_pkg::SPD_1000))
        else $error("negotiation enable wrong");
    cfg_staged_a: assert property ($changed(active_cfg) |->
        ##[0:1] (an_restart || copper_sw_reset))
        else $error("live config changed without trigger");
    swrst_length_a: assert property ($rose(copper_sw_reset) |->
        copper_sw_reset[*8] ##1 copper_sw_reset ##1 copper_sw_reset)
        else $error("soft reset too short");
    swrst_clears_a: assert property ($rose(copper_sw_reset) |-> ##[1:12] !copper_sw_reset)
        else $error("soft reset never clears");
    swrst_restart_a: assert property ($fell(copper_sw_reset) |-> ##[0:1] an_restart)
        else $error("no restart after soft reset");
    restart_pulse_a: assert property (an_restart |=> !an_restart)
        else $error("restart not self-clearing");
endmodule // cpc_ctrl_monitor

bind cpc_ctrl cpc_ctrl_monitor u_mon (.clk(clk), .reset_n(reset_n), .pready(pready),
    .pslverr(pslverr), .copper_sw_reset(copper_sw_reset), .an_restart(an_restart),
    .active_cfg(active_cfg), .an_enable_eff(an_enable_eff), .adv_1000_only(adv_1000_only),
    .loopback_en(loopback_en), .line_link_drop(line_link_drop));
`default_nettype wire

/* File: testbench/cpc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module cpc_host (
    // Clock
    input wire logic        clk,
    // APB master
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [11:0]     paddr,
    output logic [31:0]     pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr
);
    logic tmo;

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, tmo} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Random idle gap mixes prompt and slow hosts; released address and data show inverted values
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        begin
            repeat ($urandom_range(3, 1)) @(posedge clk);
            psel   <= 1'b1;
            pwrite <= w;
            paddr  <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            for (n = 0; n < 50 && pready !== 1'b1; n++)
                @(posedge clk);
            tmo = (n >= 50);
            r = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            paddr   <= ~a;
            pwdata  <= ~d;
        end
    endtask
endmodule // cpc_host
`default_nettype wire

/* File: testbench/tb_copper_port_control_register.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_copper_port_control_register;
    localparam logic [11:0] CTRL = cpc_pkg::ADDR_CTRL;
    localparam logic [11:0] AUX  = cpc_pkg::ADDR_AUX;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] mode;
    logic pds;
    logic psel, penable, pwrite, pready, pslverr, swr, rst, aneff, adv, lbe, lld, pdn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [2:0] lbs;
    cpc_pkg::cpc_cfg_s cfg;
    logic [15:0] stg;
    logic [3:0] aux, act;
    logic e;
    int miscompares = 0;
    int n_tests = 0;

    always #5 clk = ~clk;

    cpc_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    // Both straps random from a fixed seed, so each run sees only one reset value of the power down bit
    cpc_ctrl u_dut (.clk(clk), .reset_n(reset_n), .power_down_strap(pds), .mode_strap(mode),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .copper_sw_reset(swr),
        .an_restart(rst), .active_cfg(cfg), .an_enable_eff(aneff), .adv_1000_only(adv),
        .loopback_en(lbe), .line_link_drop(lld), .loopback_speed(lbs), .powered_down(pdn));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        u_host.xfer(w, a, d, r, e);
        if (u_host.tmo)
        begin
            miscompares++;
            give_verdict();
        end
    endtask

    task automatic look();
        logic f;
        f = !act[0] && act[3:2] == cpc_pkg::SPD_1000;
        xfer(1'b0, CTRL, 32'h0);
        chk(r, {16'h0, stg});
        chk(32'({cfg, aneff, adv, lbe, lld, lbs, pdn}), 32'({act, act[0] | f, f, stg[14],
            stg[14], aux[2:0], stg[11] | aux[3]}));
    endtask

    // Model: staged bits apply on soft reset, restart or wake; wake does both
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic pdo, wake, rs;
        int ns, np;
        pdo = stg[11] | aux[3];
        xfer(1'b1, a, {16'h0, d});
        if (a == CTRL)
            stg = d & 16'h7940;
        else
            aux = d[3:0];
        wake = pdo && !(stg[11] | aux[3]);
        rs = (a == CTRL && d[15]) || wake;
        if (rs && a != CTRL)
            stg[14] = 1'b0;
        if (rs || (a == CTRL && d[9]))
            act = {stg[6], stg[13], stg[8], stg[12]};
        ns = 0;
        np = 0;
        repeat (16)
        begin
            @(posedge clk);
            ns += (swr === 1'b1);
            np += (rst === 1'b1);
        end
        chk(32'(ns), rs ? 32'hA : 32'h0);
        chk(32'(np), 32'(rs) + 32'(wake || (a == CTRL && d[9])));
        look();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hA738));
        mode = 3'($urandom);
        pds = 1'($urandom);
        stg = 16'h1140 | {4'h0, pds && (mode[2] == mode[1]), 11'h0};
        aux = 4'h0;
        act = {stg[6], stg[13], stg[8], stg[12]};
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({31'h0, rst}, 32'h1);
        chk({31'h0, swr}, 32'h0);
        look();
        $display("test reset done");
        wr(CTRL, 16'h1140);
        wr(AUX, 16'h0008);
        wr(CTRL, 16'h1140);
        wr(AUX, 16'h0000);
        $display("test power down done");
        for (int s = 0; s < 4; s++)
        begin
            wr(CTRL, {2'h0, s[0], s[0], 3'h0, 1'($urandom), 1'b0, s[1], 6'h00});
            wr(CTRL, stg | 16'h0200);
        end
        $display("test speed done");
        wr(AUX, {13'h0, 3'($urandom)});
        wr(CTRL, 16'h4540);
        wr(AUX, {12'h0, 1'b1, aux[2:0]});
        wr(AUX, {13'h0, aux[2:0]});
        $display("test loopback done");
        wr(CTRL, 16'hA100);
        $display("test soft reset done");
        xfer(1'b0, 12'hFFC, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        $display("test unmapped done");
        give_verdict();
    end
endmodule // tb_copper_port_control_register
`default_nettype wire
